// ---- src/ilb_pkg.sv ----
// Shared constants of the lighting bus bridge
`default_nettype none
package ilb_pkg;
  // Clock and lighting bus timing
  localparam int unsigned CLK_HZ         = 200_000_000; // System clock
  localparam int unsigned BIT_RATE_HZ    = 1200;        // Bus bit rate
  localparam int unsigned HALF_BIT_CYC   = CLK_HZ / (2 * BIT_RATE_HZ); // Half bit
  localparam int unsigned FAULT_TIME_MS  = 500;         // Low time counted as fault
  localparam int unsigned FAULT_CYC      = FAULT_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned HOLD_TIME_MS   = 400;         // Press longer = hold
  localparam int unsigned HOLD_CYC       = HOLD_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned REPEAT_TIME_MS = 200;         // Fade step while held
  localparam int unsigned REPEAT_CYC     = REPEAT_TIME_MS * (CLK_HZ / 1000);
  // Frame shape in half bits: start, 16 data, stop
  localparam logic [5:0]  FRAME_HALVES   = 6'h26;
  // I2C target address after reset
  localparam logic [6:0]  I2C_ADDR_RST   = 7'h20;
  // Register numbers
  localparam logic [7:0]  REG_STATUS     = 8'h00;
  localparam logic [7:0]  REG_CMD        = 8'h01;
  localparam logic [7:0]  REG_CMD_DATA   = 8'h02; // Second command byte
  localparam logic [7:0]  REG_SETUP      = 8'h08;
  localparam logic [7:0]  REG_SETUP_LAST = 8'h0B;
  localparam logic [7:0]  REG_ADDR_CHG   = 8'hFE;
  localparam logic [7:0]  REG_ADDR_CHK   = 8'hFF; // Complement byte
  localparam logic [31:0] SETUP_RST      = 32'hFE00_FE00; // Mode 0, broadcast
  // Status bits
  localparam int unsigned STAT_FAULT_BIT = 7;
  localparam int unsigned STAT_BUSY_BIT  = 6;
  // Address byte layout
  localparam int unsigned ADR_GROUP_BIT  = 7;
  localparam int unsigned ADR_SEL_BIT    = 0;
  localparam logic [7:0]  ADR_BAD_LO     = 8'hA0;
  localparam logic [7:0]  ADR_BAD_HI     = 8'hFD;
  // Command codes
  localparam logic [7:0]  CODE_MAX_OK    = 8'h1F;
  localparam logic [7:0]  CODE_OFF       = 8'h00;
  localparam logic [7:0]  CODE_UP        = 8'h01;
  localparam logic [7:0]  CODE_DOWN      = 8'h02;
  localparam logic [7:0]  CODE_MAX_LEVEL = 8'h05;
  // I2C target states
  typedef enum logic [2:0] {
    I2C_IDLE,
    I2C_ADDR,
    I2C_WDATA,
    I2C_ACK,
    I2C_RDATA,
    I2C_RACK
  } ilb_i2c_st_t;
endpackage
`default_nettype wire

// ---- src/ilb_frame_tx.sv ----
// Manchester forward frame sender for the lighting bus
`default_nettype none
module ilb_frame_tx #(
  parameter int unsigned HALF_BIT_CYC = ilb_pkg::HALF_BIT_CYC // Cycles per half bit
) (
  input  wire logic        clk_i,   // System clock
  input  wire logic        srst_i,  // Synchronous reset
  input  wire logic        start_i, // Send frame_i, one cycle
  input  wire logic [15:0] frame_i, // Address byte then data byte
  output logic             tx_o,    // Bus level, high = bus high
  output logic             done_o   // Frame fully sent, one cycle
);

  typedef struct packed {
    logic [37:0] pat;  // Remaining half bits, MSB next
    logic [31:0] hcnt; // Cycles into current half bit
    logic [5:0]  left; // Half bits still on the wire
    logic        tx;   // Line level
    logic        done; // End pulse
  } ilb_tx_state_t;

  ilb_tx_state_t r;
  ilb_tx_state_t n;

  // Start bit, data MSB first, then stop
  function automatic logic [37:0] build(input logic [15:0] f);
    logic [37:0] p;
    p = 38'h0;
    p[37:36] = 2'b01;
    p[3:0] = 4'hF;
    for (int i = 0; i < 16; i++) begin
      p[4 + 2 * i +: 2] = {~f[i], f[i]};
    end
    return p;
  endfunction

  // Next state: load on start, step one half bit per period
  always_comb begin
    logic [37:0] p;
    p = build(frame_i);
    n = r;
    n.done = 1'b0;
    if (r.left == 6'h00) begin
      // Idle line stays high
      n.tx = 1'b1;
      if (start_i) begin
        n.tx = p[37];
        n.pat = {p[36:0], 1'b1};
        n.left = ilb_pkg::FRAME_HALVES;
        n.hcnt = 32'h0;
      end
    end else if (r.hcnt >= HALF_BIT_CYC - 1) begin
      n.hcnt = 32'h0;
      n.left = r.left - 6'h01;
      if (r.left == 6'h01) begin
        // Last stop half done
        n.done = 1'b1;
        n.tx = 1'b1;
      end else begin
        n.tx = r.pat[37];
        n.pat = {r.pat[36:0], 1'b1};
      end
    end else begin
      n.hcnt = r.hcnt + 32'h1;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      r <= '0;
      r.tx <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign tx_o = r.tx;
  assign done_o = r.done;

endmodule
`default_nettype wire

// ---- src/ilb_bridge.sv ----
// I2C register target that forwards lamp commands to the lighting bus
`default_nettype none

// What this block does
// [RULE1] Answer I2C at 0x20 until moved
// [RULE2] First written byte loads register pointer
// [RULE3] Host writes pointer, restarts, then reads
// [RULE4] Pointer clears to zero at stop
// [RULE5] Status bit 7 shows bus fault
// [RULE6] Status bit 6 shows command in flight
// [RULE7] Long low bus means fault
// [RULE8] Fault drops command writes
// [RULE9] Busy drops command writes
// [RULE10] Address byte then data byte, sent together
// [RULE11] Only codes 0..31 or power levels sent
// [RULE12] Bit 7 group select, bits 6..1 address
// [RULE13] Bit 0 picks power level or code
// [RULE14] Short address picks one of 64
// [RULE15] Group form picks one of 16
// [RULE16] All address ones means broadcast
// [RULE17] Address bytes A0..FD are dropped
// [RULE18] Power level byte passes unchanged
// [RULE19] Command codes pass through as given
// [RULE20] Held switch repeats fade every 200 ms
// [RULE21] Bus pins are positive logic
// [RULE22] Default switches: tap on/off, hold dims
// [RULE23] Setup bytes: mode0, addr0, mode1, addr1; both switches send to addr0
// [RULE24] Address change needs value then complement
// [RULE25] Status bits 5..0 read zero
// [RULE26] Busy sets on the accepting cycle
module ilb_bridge #(
  parameter int unsigned HALF_BIT_CYC = ilb_pkg::HALF_BIT_CYC, // Half bit cycles
  parameter int unsigned FAULT_CYC    = ilb_pkg::FAULT_CYC,    // Low time to fault
  parameter int unsigned HOLD_CYC     = ilb_pkg::HOLD_CYC,     // Press to hold
  parameter int unsigned REPEAT_CYC   = ilb_pkg::REPEAT_CYC    // Fade repeat
) (
  input  wire logic clk_i,              // System clock
  input  wire logic srst_i,             // Synchronous reset
  input  wire logic scl_i,              // I2C clock level
  output logic      scl_o,              // I2C clock drive value
  output logic      scl_oe_o,           // I2C clock pull low
  input  wire logic sda_i,              // I2C data level
  output logic      sda_o,              // I2C data drive value
  output logic      sda_oe_o,           // I2C data pull low
  input  wire logic bus_receive_in_i,   // Lighting bus level
  output logic      bus_transmit_out_o, // Lighting bus drive
  input  wire logic switch_input_0_i,   // Switch 0, low = pressed
  input  wire logic switch_input_1_i    // Switch 1, low = pressed
);

  // All state of the bridge
  typedef struct packed {
    logic                 scl_m;     // Sync first stage
    logic                 scl_s;     // Sync second stage
    logic                 scl_d;     // Previous synced value
    logic                 sda_m;
    logic                 sda_s;
    logic                 sda_d;
    logic                 rx_m;
    logic                 rx_s;
    logic                 sw0_m;
    logic                 sw0_s;
    logic                 sw1_m;
    logic                 sw1_s;
    ilb_pkg::ilb_i2c_st_t st;        // I2C target state
    logic [3:0]           bit_cnt;   // Bits of current byte
    logic [7:0]           shreg;     // Byte in or out
    logic                 rd;        // Read transfer
    logic                 ptr_phase; // Next write byte is pointer
    logic [7:0]           ptr;       // Register pointer
    logic                 sda_oe;    // Pull data low
    logic [7:0]           cmd_addr;  // First command byte
    logic [7:0]           chg_addr;  // Pending new I2C address
    logic [31:0]          setup;     // Switch setup bytes
    logic [6:0]           dev_addr;  // Own I2C address
    logic                 busy;      // Frame in flight
    logic                 fault;     // Bus fault
    logic [31:0]          fault_cnt; // Cycles of low bus
    logic                 tx_start;  // Start pulse to sender
    logic [15:0]          tx_frame;  // Frame to sender
    logic                 sw_act;    // A press is tracked
    logic                 sw_which;  // Tracked switch
    logic                 sw_held;   // Press turned into hold
    logic [31:0]          sw_cnt;    // Press timer
    logic                 sw_pend;   // Switch frame waiting
    logic [15:0]          sw_frame;  // Waiting switch frame
  } ilb_bridge_state_t;

  ilb_bridge_state_t r;        // Registered state
  ilb_bridge_state_t n;        // Next state
  logic              tx_done;  // Sender finished
  logic              tx_line;  // Sender line level
  logic              scl_rise; // Synced clock edges
  logic              scl_fall;
  logic              i2c_start; // Start or repeated start
  logic              i2c_stop;  // Stop condition

  // Address bytes in A0..FD are not valid targets
  function automatic logic addr_ok(input logic [7:0] a);
    // [RULE17] drop reserved range
    return !((a >= ilb_pkg::ADR_BAD_LO) && (a <= ilb_pkg::ADR_BAD_HI));
  endfunction

  // Whole command check before it is sent
  function automatic logic cmd_ok(input logic [7:0] a, input logic [7:0] d);
    // [RULE11] codes limited, levels free
    return addr_ok(a) && (!a[ilb_pkg::ADR_SEL_BIT] || (d <= ilb_pkg::CODE_MAX_OK));
  endfunction

  // Byte the host reads at a pointer
  function automatic logic [7:0] read_byte(input logic [7:0] p,
                                           input ilb_bridge_state_t s);
    logic [7:0] b;
    b = 8'h00;
    if (p == ilb_pkg::REG_STATUS) begin
      // [RULE5] fault in bit 7
      b[ilb_pkg::STAT_FAULT_BIT] = s.fault;
      // [RULE6] busy in bit 6
      b[ilb_pkg::STAT_BUSY_BIT] = s.busy;
      // [RULE25] low bits stay zero
    end else if (p >= ilb_pkg::REG_SETUP && p <= ilb_pkg::REG_SETUP_LAST) begin
      b = s.setup[{p[1:0], 3'b000} +: 8];
    end
    return b;
  endfunction

  // Bus conditions seen on the synced pins
  assign scl_rise  = r.scl_s & ~r.scl_d;
  assign scl_fall  = ~r.scl_s & r.scl_d;
  assign i2c_start = r.scl_s & r.scl_d & r.sda_d & ~r.sda_s;
  assign i2c_stop  = r.scl_s & r.scl_d & ~r.sda_d & r.sda_s;

  // Next state of the whole bridge
  always_comb begin
    logic       accept;  // I2C command taken this cycle
    logic [7:0] sw_adr;  // Address used by switches
    logic [7:0] sw_code; // Code a switch wants sent
    logic       sw_send; // Switch wants a frame
    accept = 1'b0;
    sw_send = 1'b0;
    sw_code = ilb_pkg::CODE_OFF;
    // [RULE23] switch 0 address is setup byte 1
    sw_adr = {r.setup[15:9], 1'b1};
    n = r;
    n.tx_start = 1'b0;

    // Two flip-flops on every pin input
    n.scl_m = scl_i;
    n.scl_s = r.scl_m;
    n.scl_d = r.scl_s;
    n.sda_m = sda_i;
    n.sda_s = r.sda_m;
    n.sda_d = r.sda_s;
    // [RULE21] high pin is high bus
    n.rx_m = bus_receive_in_i;
    n.rx_s = r.rx_m;
    n.sw0_m = switch_input_0_i;
    n.sw0_s = r.sw0_m;
    n.sw1_m = switch_input_1_i;
    n.sw1_s = r.sw1_m;

    // [RULE7] long low bus is a fault
    if (!r.rx_s) begin
      // A stuck or unpowered bus reads low
      if (r.fault_cnt >= FAULT_CYC - 1) begin
        n.fault = 1'b1;
      end else begin
        n.fault_cnt = r.fault_cnt + 32'h1;
      end
    end else begin
      // Any high level ends the fault
      n.fault_cnt = 32'h0;
      n.fault = 1'b0;
    end

    // Sender finished, ready for the next frame
    if (tx_done) begin
      n.busy = 1'b0;
    end

    // I2C target
    if (i2c_start) begin
      // Repeated start keeps the pointer for a read
      n.st = ilb_pkg::I2C_ADDR;
      n.bit_cnt = 4'h0;
      n.sda_oe = 1'b0;
    end else if (i2c_stop) begin
      // [RULE4] pointer back to status
      n.st = ilb_pkg::I2C_IDLE;
      n.ptr = ilb_pkg::REG_STATUS;
      n.ptr_phase = 1'b0;
      n.sda_oe = 1'b0;
    end else begin
      case (r.st)
        ilb_pkg::I2C_ADDR, ilb_pkg::I2C_WDATA: begin
          if (scl_rise) begin
            // Data is stable while the clock is high
            n.shreg = {r.shreg[6:0], r.sda_s};
            n.bit_cnt = r.bit_cnt + 4'h1;
          end else if (scl_fall && r.bit_cnt == 4'h8) begin
            n.bit_cnt = 4'h0;
            if (r.st == ilb_pkg::I2C_ADDR) begin
              // [RULE1] match own address only
              if (r.shreg[7:1] == r.dev_addr) begin
                n.rd = r.shreg[0];
                n.ptr_phase = ~r.shreg[0];
                n.sda_oe = 1'b1;
                n.st = ilb_pkg::I2C_ACK;
              end else begin
                // Not for us, wait for the next start
                n.st = ilb_pkg::I2C_IDLE;
              end
            end else begin
              n.sda_oe = 1'b1;
              n.st = ilb_pkg::I2C_ACK;
              if (r.ptr_phase) begin
                // [RULE2] first byte is the pointer
                n.ptr = r.shreg;
                n.ptr_phase = 1'b0;
              end else begin
                // Multi-byte registers fill in order
                n.ptr = r.ptr + 8'h01;
                case (r.ptr)
                  ilb_pkg::REG_CMD: begin
                    // [RULE10] address byte comes first
                    n.cmd_addr = r.shreg;
                  end
                  ilb_pkg::REG_CMD_DATA: begin
                    // [RULE8] fault drops the command
                    // [RULE9] busy drops the command
                    if (!r.fault && !r.busy && cmd_ok(r.cmd_addr, r.shreg)) begin
                      // [RULE10] pair sent as one frame
                      n.tx_frame = {r.cmd_addr, r.shreg};
                      n.tx_start = 1'b1;
                      // [RULE26] busy from the accepting cycle
                      n.busy = 1'b1;
                      accept = 1'b1;
                    end
                  end
                  ilb_pkg::REG_ADDR_CHG: begin
                    n.chg_addr = r.shreg;
                  end
                  ilb_pkg::REG_ADDR_CHK: begin
                    // [RULE24] value below 128, complement matches
                    if (!r.chg_addr[7] && (r.shreg == ~r.chg_addr)) begin
                      n.dev_addr = r.chg_addr[6:0];
                    end
                  end
                  default: begin
                    // [RULE23] four setup bytes in order
                    if (r.ptr >= ilb_pkg::REG_SETUP && r.ptr <= ilb_pkg::REG_SETUP_LAST) begin
                      n.setup[{r.ptr[1:0], 3'b000} +: 8] = r.shreg;
                    end
                  end
                endcase
              end
            end
          end
        end
        ilb_pkg::I2C_ACK: begin
          // Ack bit ends at the falling clock
          if (scl_fall) begin
            n.bit_cnt = 4'h0;
            if (r.rd) begin
              // [RULE3] read starts at the pointer set earlier
              n.shreg = read_byte(r.ptr, r);
              n.sda_oe = ~n.shreg[7];
              n.st = ilb_pkg::I2C_RDATA;
            end else begin
              n.sda_oe = 1'b0;
              n.st = ilb_pkg::I2C_WDATA;
            end
          end
        end
        ilb_pkg::I2C_RDATA: begin
          if (scl_rise) begin
            n.bit_cnt = r.bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (r.bit_cnt == 4'h8) begin
              // Free the line for the host ack
              n.sda_oe = 1'b0;
              n.st = ilb_pkg::I2C_RACK;
            end else begin
              n.shreg = {r.shreg[6:0], 1'b0};
              n.sda_oe = ~r.shreg[6];
            end
          end
        end
        ilb_pkg::I2C_RACK: begin
          if (scl_rise) begin
            if (r.sda_s) begin
              // Host said no more
              n.st = ilb_pkg::I2C_IDLE;
            end else begin
              n.ptr = r.ptr + 8'h01;
            end
          end else if (scl_fall) begin
            n.bit_cnt = 4'h0;
            n.shreg = read_byte(r.ptr, r);
            n.sda_oe = ~n.shreg[7];
            n.st = ilb_pkg::I2C_RDATA;
          end
        end
        ilb_pkg::I2C_IDLE: begin
          n.sda_oe = 1'b0;
        end
        default: begin
          n.st = ilb_pkg::I2C_IDLE;
          n.sda_oe = 1'b0;
        end
      endcase
    end

    // Hand a waiting switch frame to the sender
    if (r.sw_pend && !accept) begin
      if (r.fault) begin
        // [RULE8] nothing goes out on a broken bus
        n.sw_pend = 1'b0;
      end else if (!n.busy) begin
        n.tx_frame = r.sw_frame;
        n.tx_start = 1'b1;
        n.busy = 1'b1;
        n.sw_pend = 1'b0;
      end
    end

    // [RULE22] factory mode: two switch dimming
    // No debounce: a bouncing contact may send extra taps
    if (!r.sw_act) begin
      if (!r.sw0_s || !r.sw1_s) begin
        n.sw_act = 1'b1;
        n.sw_which = r.sw0_s;
        n.sw_held = 1'b0;
        n.sw_cnt = 32'h0;
      end
    end else if (r.sw_which ? !r.sw1_s : !r.sw0_s) begin
      // [RULE20] fade again every 200 ms while held
      if (r.sw_cnt >= (r.sw_held ? REPEAT_CYC : HOLD_CYC) - 1) begin
        n.sw_cnt = 32'h0;
        n.sw_held = 1'b1;
        sw_send = 1'b1;
        sw_code = r.sw_which ? ilb_pkg::CODE_DOWN : ilb_pkg::CODE_UP;
      end else begin
        n.sw_cnt = r.sw_cnt + 32'h1;
      end
    end else begin
      // Release: a short tap switches on or off
      n.sw_act = 1'b0;
      if (!r.sw_held) begin
        sw_send = 1'b1;
        sw_code = r.sw_which ? ilb_pkg::CODE_OFF : ilb_pkg::CODE_MAX_LEVEL;
      end
    end
    // Newest switch event replaces an unsent one
    if (sw_send && addr_ok(sw_adr)) begin
      n.sw_pend = 1'b1;
      n.sw_frame = {sw_adr, sw_code};
    end
  end

  // State register; pins idle high so no false start after reset
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      r <= '0;
      r.scl_m <= 1'b1;
      r.scl_s <= 1'b1;
      r.scl_d <= 1'b1;
      r.sda_m <= 1'b1;
      r.sda_s <= 1'b1;
      r.sda_d <= 1'b1;
      r.rx_m <= 1'b1;
      r.rx_s <= 1'b1;
      r.sw0_m <= 1'b1;
      r.sw0_s <= 1'b1;
      r.sw1_m <= 1'b1;
      r.sw1_s <= 1'b1;
      r.dev_addr <= ilb_pkg::I2C_ADDR_RST;
      r.setup <= ilb_pkg::SETUP_RST;
    end else begin
      r <= n;
    end
  end

  // Frame sender; address byte passes untouched
  // [RULE12] group bit and address bits kept
  // [RULE13] select bit kept in frame
  // [RULE14] short addresses sent as given
  // [RULE15] group addresses sent as given
  // [RULE16] broadcast byte sent as given
  // [RULE18] power byte sent unchanged
  // [RULE19] command code sent unchanged
  ilb_frame_tx #(
    .HALF_BIT_CYC (HALF_BIT_CYC)
  ) u_frame_tx (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .start_i (r.tx_start),
    .frame_i (r.tx_frame),
    .tx_o    (tx_line),
    .done_o  (tx_done)
  );

  // Data pin pulls low only; clock never stretched
  assign sda_o = 1'b0;
  assign sda_oe_o = r.sda_oe;
  assign scl_o = 1'b0;
  assign scl_oe_o = 1'b0;
  // [RULE21] high output is high bus
  assign bus_transmit_out_o = tx_line;

endmodule
`default_nettype wire

// ---- sim/ilb_bridge_chk.sv ----
// Concurrent checks on the pins of the lighting bus bridge
`default_nettype none
module ilb_bridge_chk #(
  parameter int unsigned HALF_BIT_CYC = 8,  // Cycles per half bit
  parameter int unsigned FAULT_CYC    = 200 // Low time counted as fault
) (
  input wire logic clk_i,              // System clock
  input wire logic srst_i,             // Synchronous reset
  input wire logic scl_i,              // I2C clock level
  input wire logic scl_o,              // I2C clock drive value
  input wire logic scl_oe_o,           // I2C clock pull low
  input wire logic sda_o,              // I2C data drive value
  input wire logic sda_oe_o,           // I2C data pull low
  input wire logic bus_receive_in_i,   // Lighting bus level
  input wire logic bus_transmit_out_o  // Lighting bus drive
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] lo_cnt; // Sender low run
  logic [15:0] hi_cnt; // Sender high run, saturating
  logic [15:0] rx_cnt; // Bus low run, saturating
  // Run lengths; high run starts full so reset looks idle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lo_cnt <= 16'h0000;
      hi_cnt <= 16'hFFFF;
      rx_cnt <= 16'h0000;
    end else begin
      lo_cnt <= bus_transmit_out_o ? 16'h0000 : lo_cnt + 16'h0001;
      hi_cnt <= !bus_transmit_out_o ? 16'h0000 : hi_cnt + 16'(hi_cnt != 16'hFFFF);
      rx_cnt <= bus_receive_in_i ? 16'h0000 : rx_cnt + 16'(rx_cnt != 16'hFFFF);
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  chk_reset_idle: assert property ($fell(srst_i) |-> bus_transmit_out_o && !sda_oe_o)
    else $error("Pins not idle after reset");
  chk_open_drain: assert property (!scl_oe_o && !scl_o && !sda_o)
    else $error("I2C pin driven high");
  chk_ack_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("Data moved, clock high");
  chk_ack_stands: assert property ($rose(sda_oe_o) |-> sda_oe_o [*8])
    else $error("Data pull low too short");
  chk_low_run: assert property ($rose(bus_transmit_out_o) |->
    (lo_cnt == HALF_BIT_CYC) || (lo_cnt == 2 * HALF_BIT_CYC))
    else $error("Bad low run");
  chk_low_max: assert property (lo_cnt <= 2 * HALF_BIT_CYC)
    else $error("Low run too long");
  chk_high_run: assert property ($fell(bus_transmit_out_o) |-> (hi_cnt == HALF_BIT_CYC) ||
    (hi_cnt == 2 * HALF_BIT_CYC) || (hi_cnt >= 4 * HALF_BIT_CYC))
    else $error("Bad high run");
  chk_fault_mute: assert property ((rx_cnt > FAULT_CYC + 8) |-> !$fell(bus_transmit_out_o))
    else $error("Frame sent on faulty bus");
endmodule
`default_nettype wire

// ---- sim/ilb_bus_model.sv ----
// Lighting bus model with frame decoder
`default_nettype none
module ilb_bus_model #(
  parameter int unsigned HALF_BIT_CYC = 8 // Cycles per half bit
) (
  input  wire logic        clk_i,        // System clock
  input  wire logic        tx_i,         // Bridge drive level
  input  wire logic        stuck_i,      // Hold bus low
  output logic             rx_o,         // Bus level seen by bridge
  output logic [15:0]      frame_o,      // Last decoded frame
  output logic             frame_valid_o // One cycle per frame
);
  timeunit 1ns;
  timeprecision 1ps;
  assign rx_o = tx_i & ~stuck_i;
  // Decode mid half; broken pair gives x
  initial begin
    logic        a;
    logic [15:0] f;
    frame_valid_o = 1'b0;
    frame_o = 16'h0000;
    forever begin
      @(negedge tx_i);
      repeat (2 * HALF_BIT_CYC + HALF_BIT_CYC / 2) @(negedge clk_i);
      for (int i = 15; i >= 0; i--) begin
        a = tx_i;
        repeat (HALF_BIT_CYC) @(negedge clk_i);
        f[i] = (a != tx_i) ? tx_i : 1'bx;
        repeat (HALF_BIT_CYC) @(negedge clk_i);
      end
      @(posedge clk_i) frame_o <= f;
      frame_valid_o <= 1'b1;
      @(posedge clk_i) frame_valid_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- sim/ilb_bridge_tb.sv ----
// Bench for the lighting bus bridge
`default_nettype none
module ilb_bridge_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned H = 64;    // Slow so busy shows
  localparam int unsigned FLT = 200; // Stuck-low time to fault
  logic clk_i = 1'b0, srst_i = 1'b1, scl_h = 1'b1, sda_h = 1'b1, sw0 = 1'b1, sw1 = 1'b1;
  logic stuck = 1'b0, scl_o, scl_oe_o, sda_o, sda_oe_o, tx, rx, fv;
  logic [15:0] fr;         // Decoded frame
  logic [15:0] expq[$];    // Owed frames
  logic [6:0]  dev = 7'h20; // Target address
  int          mismatches = 0, checks = 0;
  wire         scl_w = scl_h & ~scl_oe_o; // Open-drain wire levels
  wire         sda_w = sda_h & ~sda_oe_o;
  always #2.5 clk_i = ~clk_i;
  ilb_bridge #(.HALF_BIT_CYC(H), .FAULT_CYC(FLT), .HOLD_CYC(100), .REPEAT_CYC(60)) dut (
    .clk_i(clk_i), .srst_i(srst_i), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .bus_receive_in_i(rx),
    .bus_transmit_out_o(tx), .switch_input_0_i(sw0), .switch_input_1_i(sw1));
  ilb_bus_model #(.HALF_BIT_CYC(H)) bus (.clk_i(clk_i), .tx_i(tx), .stuck_i(stuck),
    .rx_o(rx), .frame_o(fr), .frame_valid_o(fv));
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] e);
    checks++;
    if (seen !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One 160 ns SCL period
  task automatic bit_(input logic b, output logic r);
    w(8); sda_h <= b; w(8); scl_h <= 1'b1; w(16); r = sda_w; scl_h <= 1'b0;
  endtask
  task automatic start_();
    w(8); sda_h <= 1'b1; w(8); scl_h <= 1'b1; w(16); sda_h <= 1'b0; w(16); scl_h <= 1'b0;
  endtask
  task automatic stop_();
    w(8); sda_h <= 1'b0; w(8); scl_h <= 1'b1; w(16); sda_h <= 1'b1; w(16);
  endtask
  task automatic wb(input logic [7:0] d, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bit_(d[i], r);
    bit_(1'b1, r);
    a = !r;
  endtask
  task automatic rb(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_(1'b1, r);
      d[i] = r;
    end
    bit_(nak, r);
  endtask
  task automatic probe(input logic [6:0] ad, input logic ea);
    logic a;
    start_(); wb({ad, 1'b0}, a); stop_();
    chk("addr ack", 16'(a), 16'(ea));
  endtask
  task automatic wr(input logic [7:0] rg, input logic [31:0] d, input int n);
    logic a;
    start_(); wb({dev, 1'b0}, a); wb(rg, a);
    for (int i = 0; i < n; i++) wb(d[8*i+:8], a);
    stop_();
    chk("write ack", 16'(a), 16'h0001);
  endtask
  task automatic rd(input logic [7:0] rg, input int n, input logic [31:0] e, input logic setp);
    logic       a;
    logic [7:0] d;
    if (setp) begin
      start_(); wb({dev, 1'b0}, a); wb(rg, a);
    end
    start_(); wb({dev, 1'b1}, a);
    for (int i = 0; i < n; i++) begin
      rb(i == n - 1, d);
      chk("read", 16'(d), 16'(e[8*i+:8]));
    end
    stop_();
  endtask
  task automatic drain();
    for (int k = 0; k < 6000 && expq.size() != 0; k++) w(1);
    if (expq.size() != 0) begin
      mismatches++;
      close_out();
    end
  endtask
  // Oldest owed frame per decoded one
  always @(posedge clk_i) if (fv) chk("frame", fr, expq.size() ? expq.pop_front() : 16'hXXXX);
  initial begin
    logic        s;
    logic [7:0]  ab, db;
    logic [31:0] d;
    static logic [15:0] rej [3] = '{16'h00A1, 16'h00FD, 16'h20FF};
    void'($urandom(50141));
    w(3); srst_i <= 1'b0; w(4);
    rd(8'h00, 1, 32'h0, 1'b0);
    probe(7'h21, 1'b0);
    for (int i = 0; i < 12; i++) begin
      s = i < 10;
      case (i % 3)
        0: ab = {1'b0, 6'($urandom), s};
        1: ab = {3'b100, 4'($urandom), s};
        default: ab = {7'h7F, s};
      endcase
      db = (i < 9) ? 8'(i) : (i == 9) ? 8'h1F : (i == 10) ? 8'hFF : 8'($urandom);
      expq.push_back({ab, db});
      wr(8'h01, {16'h0, db, ab}, 2);
      if (i == 0) begin
        wr(8'h01, {16'h0, 8'h05, ab}, 2);
        rd(8'h00, 1, 32'h40, 1'b0);
      end
      drain();
    end
    for (int j = 0; j < 3; j++) begin
      wr(8'h01, {16'h0, rej[j]}, 2);
      rd(8'h00, 1, 32'h0, 1'b0);
    end
    stuck <= 1'b1; w(FLT + 20);
    rd(8'h00, 1, 32'h80, 1'b1);
    wr(8'h01, 32'h0000_05FF, 2);
    rd(8'h00, 1, 32'h80, 1'b0);
    stuck <= 1'b0; w(20);
    rd(8'h00, 1, 32'h0, 1'b0);
    expq.push_back(16'hFF05);
    sw0 <= 1'b0; w(40); sw0 <= 1'b1; drain();
    expq.push_back(16'hFF00);
    sw1 <= 1'b0; w(40); sw1 <= 1'b1; drain();
    rd(8'h08, 4, 32'hFE00_FE00, 1'b1);
    d = $urandom;
    wr(8'h08, d, 4);
    rd(8'h08, 4, d, 1'b1);
    rd(8'h00, 1, 32'h0, 1'b0);
    wr(8'hFE, 32'h0000_0030, 2);
    probe(7'h20, 1'b1);
    wr(8'hFE, 32'h0000_CF30, 2);
    probe(7'h30, 1'b1);
    probe(7'h20, 1'b0);
    close_out();
  end
endmodule
bind ilb_bridge ilb_bridge_chk #(.HALF_BIT_CYC(HALF_BIT_CYC), .FAULT_CYC(FAULT_CYC)) chk_i (
  .clk_i(clk_i), .srst_i(srst_i), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .bus_receive_in_i(bus_receive_in_i),
  .bus_transmit_out_o(bus_transmit_out_o));
`default_nettype wire
